// [rtl/gtc_timer.sv]
// gated 16-bit timer/counter with prescaler, gate and overflow flag
// assumes one clock hclk as the instruction clock; all pins are sampled as
// synchronous inputs, so the asynchronous mode is modelled by a shorter path
//
// The placing of the registers and register access over AHB-Lite were chosen for this implementation.
module gtc_timer (
   // clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [7:0]  haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // count clock, gate and comparator
   input  wire logic        ext_count_clock_pin,
   input  wire logic        gate_pin,
   input  wire logic        second_comparator,
   // system context
   input  wire logic        sleep_mode,
   input  wire logic        primary_clock_ok,
   input  wire logic [1:0]  port_data_in,
   input  wire logic [1:0]  port_dir_in,
   // outputs to the system
   output logic             osc_run,
   output logic             display_clock_enable,
   output logic             osc_pin_a_direction,
   output logic             osc_pin_b_direction,
   output logic             irq,
   output logic             wake_request
);

   ////////////////////////////////////////////////////////////////////////
   // state
   typedef struct packed {
      logic [7:0]  ctrl;       // timer_control_reg
      logic        gate_src;   // gate_source_select
      logic [15:0] count;      // live counter
      logic [2:0]  presc;      // hidden prescale counter
      logic        flag;       // overflow_flag
      logic        irq_en;     // overflow_irq_enable
      logic        peripheral_irq_enable;       // peripheral_irq_enable
      logic        global_irq_enable;        // global_irq_enable
      logic        armed;      // falling edge seen while timer_on since last disarm
      logic        sync1;      // synchroniser first stage
      logic        sync2;      // synchroniser second stage
      logic        sync3;      // synchronised history for edge detect
      logic        araw;       // direct sample, asynchronous path
      logic        aprev;      // direct sample history
      logic        dp_wr;      // write data phase pending
      logic [7:0]  dp_addr;    // write address held for data phase
      logic [31:0] rdata;      // read data register
   } gtc_state_t;

   gtc_state_t s_q;            // registered state
   gtc_state_t s_d;            // next state

   // decoded control bits
   logic       timer_on;       // timer_on
   logic       clock_source_select;
   logic       sync_disable;
   logic       osc_enable;
   logic [1:0] prescale_select;
   logic       gate_enable;
   logic       gate_invert;

   assign timer_on            = s_q.ctrl[gtc_pkg::BIT_TIMER_ON];
   assign clock_source_select = s_q.ctrl[gtc_pkg::BIT_CLOCK_SOURCE];
   assign sync_disable        = s_q.ctrl[gtc_pkg::BIT_SYNC_DISABLE];
   assign osc_enable          = s_q.ctrl[gtc_pkg::BIT_OSC_ENABLE];
   assign prescale_select     = s_q.ctrl[gtc_pkg::BIT_PRESCALE_LO +: 2];
   assign gate_enable         = s_q.ctrl[gtc_pkg::BIT_GATE_ENABLE];
   assign gate_invert         = s_q.ctrl[gtc_pkg::BIT_GATE_INVERT];

   ////////////////////////////////////////////////////////////////////////
   // combinational helpers
   logic       addr_phase;     // address phase accepted this edge
   logic       wr_low;         // data phase write to count_low_byte
   logic       wr_high;        // data phase write to count_high_byte
   logic       wr_count;       // either count byte written
   logic       pin_now;        // pin level on the selected path
   logic       pin_prev;       // previous level on the selected path
   logic       rise;           // rising edge of the count clock
   logic       fall;           // falling edge of the count clock
   logic       gate_level;     // selected gate source
   logic       gate_active;    // gate after polarity
   logic       count_ok;       // timer running and gate open
   logic       sleep_ok;       // allowed to count under sleep
   logic       in_event;       // prescaler input event
   logic [2:0] presc_mask;     // ratio minus one
   logic       tick;           // counter increment
   logic [31:0] read_mux;      // read data selected at address phase

   assign addr_phase = hsel & htrans[1] & hready;
   assign wr_low     = s_q.dp_wr & (s_q.dp_addr == gtc_pkg::OFS_COUNT_LOW);
   assign wr_high    = s_q.dp_wr & (s_q.dp_addr == gtc_pkg::OFS_COUNT_HIGH);
   assign wr_count   = wr_low | wr_high;

   // edge sources: the synchronised path lags by one flop more, which is why
   // a switch between modes can lose or repeat one edge
   assign pin_now  = sync_disable ? s_q.araw  : s_q.sync2;
   assign pin_prev = sync_disable ? s_q.aprev : s_q.sync3;
   // edges come from registered samples only, so a glitch shorter than
   // one clock counts only if it spans a sampling edge
   assign rise     = pin_now & ~pin_prev;
   assign fall     = ~pin_now & pin_prev;

   // gate selection and polarity
   assign gate_level  = s_q.gate_src ? second_comparator : gate_pin;
   assign gate_active = gate_invert ? gate_level : ~gate_level;
   // gate enable only matters once the timer is on
   assign count_ok    = timer_on & (~gate_enable | gate_active);
   // in sleep only the asynchronous counter keeps running
   assign sleep_ok    = ~sleep_mode | (clock_source_select & sync_disable);

   // internal source gives one event per instruction cycle
   // external source needs an armed rising edge
   assign in_event = clock_source_select ? (rise & s_q.armed) : 1'b1;

   // ratio decode 00/01/10/11 -> 1/2/4/8
   assign presc_mask = 3'((gtc_pkg::PRESC_MASK_BASE << prescale_select) - gtc_pkg::PRESC_ONE);
   // the write cycle suppresses the tick, so a byte write never races
   // an increment inside this block
   assign tick       = count_ok & sleep_ok & in_event & ~wr_count
                       & ((s_q.presc & presc_mask) == presc_mask);

   ////////////////////////////////////////////////////////////////////////
   // read mux, sampled in the address phase so hrdata is a flop;
   // the counter is a synchronous register so both bytes read clean
   // hsize is not checked: every register answers to a whole word
   always_comb begin
      read_mux = 32'h0000_0000;
      unique case (haddr)
         gtc_pkg::OFS_CONTROL:    read_mux[7:0] = s_q.ctrl;
         gtc_pkg::OFS_COUNT_LOW:  read_mux[7:0] = s_q.count[7:0];
         gtc_pkg::OFS_COUNT_HIGH: read_mux[7:0] = s_q.count[15:8];
         gtc_pkg::OFS_COMPARATOR: read_mux[gtc_pkg::BIT_GATE_SOURCE] = s_q.gate_src;
         gtc_pkg::OFS_IRQ_FLAG:   read_mux[gtc_pkg::BIT_OVERFLOW] = s_q.flag;
         gtc_pkg::OFS_IRQ_ENABLE: read_mux[gtc_pkg::BIT_OVERFLOW] = s_q.irq_en;
         gtc_pkg::OFS_IRQ_CTRL: begin
            read_mux[gtc_pkg::BIT_PERIPH_IE] = s_q.peripheral_irq_enable;
            read_mux[gtc_pkg::BIT_GLOBAL_IE] = s_q.global_irq_enable;
         end
         // oscillator owns the pins: directions read one, data zero
         gtc_pkg::OFS_PIN_VIEW: begin
            read_mux[gtc_pkg::BIT_VIEW_B_DATA] = port_data_in[0] & ~osc_run;
            read_mux[gtc_pkg::BIT_VIEW_A_DATA] = port_data_in[1] & ~osc_run;
            read_mux[gtc_pkg::BIT_VIEW_B_DIR]  = port_dir_in[0] | osc_run;
            read_mux[gtc_pkg::BIT_VIEW_A_DIR]  = port_dir_in[1] | osc_run;
         end
         // unmapped addresses read zero
         default: read_mux = 32'h0000_0000;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      s_d = s_q;
      // bus address phase: capture write target, load read data
      s_d.dp_wr = addr_phase & hwrite;
      if (addr_phase) begin
         s_d.dp_addr = haddr;
         if (!hwrite) begin
            s_d.rdata = read_mux;
         end
      end
      // pin samplers: sync1 feeds only sync2
      s_d.sync1 = ext_count_clock_pin;
      s_d.sync2 = s_q.sync1;
      s_d.sync3 = s_q.sync2;
      s_d.araw  = ext_count_clock_pin;
      s_d.aprev = s_q.araw;

      // falling edge arms while running; a fall while stopped disarms,
      // so the first rise after re-enabling is not counted
      // a fall in the cycle of a count write is dropped: the write wins
      if (timer_on) begin
         if (fall) begin
            s_d.armed = 1'b1;
         end
      end else if (fall) begin
         s_d.armed = 1'b0;
      end

      // prescaler counts input events while counting is allowed
      // its phase survives a ratio change; only a tick or a count byte
      // write clears it
      if (count_ok && sleep_ok && in_event) begin
         s_d.presc = tick ? gtc_pkg::PRESC_ZERO : 3'(s_q.presc + gtc_pkg::PRESC_ONE);
      end

      // counter increment and rollover
      if (tick) begin
         s_d.count = 16'(s_q.count + gtc_pkg::COUNT_ONE);
      end

      // register writes in the data phase
      if (s_q.dp_wr) begin
         unique case (s_q.dp_addr)
            gtc_pkg::OFS_CONTROL:    s_d.ctrl = hwdata[7:0];
            gtc_pkg::OFS_COMPARATOR: s_d.gate_src = hwdata[gtc_pkg::BIT_GATE_SOURCE];
            gtc_pkg::OFS_IRQ_FLAG:   s_d.flag = hwdata[gtc_pkg::BIT_OVERFLOW];
            gtc_pkg::OFS_IRQ_ENABLE: s_d.irq_en = hwdata[gtc_pkg::BIT_OVERFLOW];
            gtc_pkg::OFS_IRQ_CTRL: begin
               s_d.peripheral_irq_enable = hwdata[gtc_pkg::BIT_PERIPH_IE];
               s_d.global_irq_enable  = hwdata[gtc_pkg::BIT_GLOBAL_IE];
            end
            // count bytes handled below, others ignored
            default: s_d.ctrl = s_q.ctrl;
         endcase
      end
      // byte write goes straight into the live counter
      if (wr_low) begin
         s_d.count[7:0] = hwdata[7:0];
      end
      if (wr_high) begin
         s_d.count[15:8] = hwdata[7:0];
      end
      // count write clears prescaler and requires a new falling edge
      if (wr_count) begin
         s_d.presc = gtc_pkg::PRESC_ZERO;
         s_d.armed = 1'b0;
      end
      // hardware set beats a software clear in the same cycle
      if (tick && (s_q.count == gtc_pkg::COUNT_MAX)) begin
         s_d.flag = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // state register
   // only the gate source resets to one, every other field to zero
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_q          <= '0;
         s_q.ctrl     <= gtc_pkg::RST_CONTROL;
         s_q.gate_src <= gtc_pkg::RST_GATE_SRC;
         s_q.count    <= gtc_pkg::RST_COUNT;
      end else begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs
   // zero wait states, always okay: the trade is a read that is one cycle old
   // hrdata stands until the next read address phase
   assign hrdata    = s_q.rdata;
   assign hreadyout = 1'b1;
   assign hresp     = gtc_pkg::HRESP_OKAY;

   // the crystal itself sits outside; only its enable leaves this block
   // oscillator runs only if the primary clock frees the circuit
   assign osc_run              = osc_enable & primary_clock_ok;
   // same oscillator offered to the display driver, sleep or not
   assign display_clock_enable = osc_run;
   // pins given to the crystal while it runs
   assign osc_pin_a_direction  = osc_run;
   assign osc_pin_b_direction  = osc_run;

   // interrupt needs all three enables
   // the flag itself is set whether or not any enable is on
   assign irq          = s_q.flag & s_q.irq_en & s_q.peripheral_irq_enable & s_q.global_irq_enable;
   // wake from sleep needs timer_on and the overflow and peripheral enables, not the global one
   // limitation: a level that holds until the flag is cleared or
   // sleep ends
   assign wake_request = sleep_mode & s_q.flag & s_q.irq_en & s_q.peripheral_irq_enable & timer_on;

   ////////////////////////////////////////////////////////////////////////
   // assertions
   // all sample on hclk and stand down while reset is low
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   a_rollover_flag: assert property (
      tick && s_q.count == gtc_pkg::COUNT_MAX |=> s_q.flag && s_q.count == gtc_pkg::RST_COUNT)
      else $error("rollover did not clear count and set flag");

   a_stopped_hold: assert property (
      !timer_on && !wr_count |=> s_q.count == $past(s_q.count))
      else $error("counter moved while stopped");

   a_low_write: assert property (
      wr_low |=> s_q.count[7:0] == $past(hwdata[7:0]))
      else $error("low byte write not taken");

   a_write_clears: assert property (
      wr_count |=> s_q.presc == gtc_pkg::PRESC_ZERO && !s_q.armed)
      else $error("count write left prescaler or arm set");

   a_div8_tick: assert property (
      tick && prescale_select == 2'h3 |-> s_q.presc == 3'h7)
      else $error("divide by eight ticked early");

   a_div1_run: assert property (
      timer_on && !clock_source_select && !gate_enable && !sleep_mode
      && prescale_select == 2'h0 && !wr_count |=> s_q.count == 16'($past(s_q.count) + 16'h0001))
      else $error("internal divide by one did not count");

   a_gate_closed: assert property (
      timer_on && gate_enable && !gate_active && !wr_count
      |=> s_q.count == $past(s_q.count))
      else $error("counted with gate closed");

   a_unarmed_edge: assert property (
      clock_source_select && !s_q.armed |-> !tick)
      else $error("counted an edge before a falling edge");

   a_sync_sleep: assert property (
      sleep_mode && !sync_disable && !wr_count |=> s_q.count == $past(s_q.count))
      else $error("synchronous mode counted asleep");

   a_flag_sticks: assert property (
      s_q.flag && !s_q.dp_wr |=> s_q.flag)
      else $error("overflow flag dropped without a write");

   // with the oscillator running the pin view hides the port levels
   a_osc_pins: assert property (
      osc_run && addr_phase && !hwrite && haddr == gtc_pkg::OFS_PIN_VIEW
      |=> hrdata[gtc_pkg::BIT_VIEW_A_DIR] && hrdata[gtc_pkg::BIT_VIEW_B_DIR]
      && !hrdata[gtc_pkg::BIT_VIEW_A_DATA] && !hrdata[gtc_pkg::BIT_VIEW_B_DATA])
      else $error("oscillator pins not forced in pin view");

   a_high_write: assert property (
      wr_high |=> s_q.count[15:8] == $past(hwdata[7:0]))
      else $error("high byte write not taken");

   a_gate_open: assert property (
      timer_on && gate_enable && gate_active && !clock_source_select && !sleep_mode
      && prescale_select == 2'h0 && !wr_count
      |=> s_q.count == 16'($past(s_q.count) + 16'h0001))
      else $error("gate open but divide by one did not count");

   c_rollover:    cover property (tick && s_q.count == gtc_pkg::COUNT_MAX);
   c_ext_count:   cover property (clock_source_select && tick);
   c_async_sleep: cover property (sleep_mode && sync_disable && tick);
   c_irq_raise:   cover property ($rose(irq));
   c_gated_tick:  cover property (gate_enable && gate_active && tick);

endmodule

// [rtl/gtc_pkg.sv]
// constants shared by the gated 16-bit timer/counter and its bench
// assumes an AHB-Lite master with 32-bit data and word-aligned single transfers
package gtc_pkg;

   // register byte offsets
   localparam logic [7:0] OFS_CONTROL    = 8'h00;  // timer_control_reg
   localparam logic [7:0] OFS_COUNT_LOW  = 8'h04;  // count_low_byte
   localparam logic [7:0] OFS_COUNT_HIGH = 8'h08;  // count_high_byte
   localparam logic [7:0] OFS_COMPARATOR = 8'h0C;  // comparator_control_reg
   localparam logic [7:0] OFS_IRQ_FLAG   = 8'h10;  // periph_irq_flag_reg
   localparam logic [7:0] OFS_IRQ_ENABLE = 8'h14;  // periph_irq_enable_reg
   localparam logic [7:0] OFS_IRQ_CTRL   = 8'h18;  // irq_control_reg
   localparam logic [7:0] OFS_PIN_VIEW   = 8'h1C;  // oscillator pin view, read only

   // timer_control_reg fields
   localparam int BIT_TIMER_ON      = 0;
   localparam int BIT_CLOCK_SOURCE  = 1;
   localparam int BIT_SYNC_DISABLE  = 2;
   localparam int BIT_OSC_ENABLE    = 3;
   localparam int BIT_PRESCALE_LO   = 4;
   localparam int BIT_GATE_ENABLE   = 6;
   localparam int BIT_GATE_INVERT   = 7;
   // comparator_control_reg, irq regs and pin view fields
   localparam int BIT_GATE_SOURCE   = 1;
   localparam int BIT_OVERFLOW      = 0;
   localparam int BIT_PERIPH_IE     = 6;
   localparam int BIT_GLOBAL_IE     = 7;
   localparam int BIT_VIEW_B_DATA   = 0;
   localparam int BIT_VIEW_A_DATA   = 1;
   localparam int BIT_VIEW_B_DIR    = 2;
   localparam int BIT_VIEW_A_DIR    = 3;

   // reset values and counter constants
   localparam logic [7:0]  RST_CONTROL    = 8'h00;
   localparam logic        RST_GATE_SRC   = 1'h1;
   localparam logic [15:0] RST_COUNT      = 16'h0000;
   localparam logic [15:0] COUNT_MAX      = 16'hFFFF;
   localparam logic [15:0] COUNT_ONE      = 16'h0001;
   localparam logic [2:0]  PRESC_ZERO     = 3'h0;
   localparam logic [2:0]  PRESC_ONE      = 3'h1;
   localparam logic [2:0]  PRESC_MASK_BASE = 3'h1;

   // ahb encodings
   localparam logic [1:0] HTRANS_IDLE = 2'h0;
   localparam logic       HRESP_OKAY  = 1'h0;

endpackage

// [tb/gtc_far_end.sv]
// far-end model: external count clock source, gate pin and second comparator
// assumes the bench calls its tasks from a process that sits on a rising hclk edge
module gtc_far_end (
   // clock
   input  wire logic hclk,
   // far-end levels
   output logic      ext_count_clock_pin,
   output logic      gate_pin,
   output logic      second_comparator
);
   timeunit 1ns;
   timeprecision 1ns;

   ////////////////////////////////////////////////////////////////////////////
   // idle: the count clock rests low between bursts, it never runs free
   initial begin
      ext_count_clock_pin = 1'b0;
      gate_pin            = 1'b0;
      second_comparator   = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // n full pulses, each level held half cycles; rise first, so the first one
   // lands before any fall and must not be counted by a freshly written timer
   task automatic pulses(input int n, input int half);
      for (int i = 0; i < n; i++) begin
         ext_count_clock_pin <= 1'b1;
         repeat (half) @(posedge hclk);
         ext_count_clock_pin <= 1'b0;
         repeat (half) @(posedge hclk);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // gate levels, changed just after an edge
   task automatic set_gate(input logic pin, input logic cmp);
      gate_pin          <= pin;
      second_comparator <= cmp;
      @(posedge hclk);
   endtask
endmodule

// [tb/tb.sv]
// top bench: ahb-lite master tasks and directed checks of the gated timer
// assumes hready is looped back from hreadyout and the far end is gtc_far_end
module tb;
   timeunit 1ns;
   timeprecision 1ns;

   // control bit values built from the package field positions
   localparam logic [7:0] TON = 8'h01 << gtc_pkg::BIT_TIMER_ON;
   localparam logic [7:0] CS  = 8'h01 << gtc_pkg::BIT_CLOCK_SOURCE;
   localparam logic [7:0] SD  = 8'h01 << gtc_pkg::BIT_SYNC_DISABLE;
   localparam logic [7:0] OSC = 8'h01 << gtc_pkg::BIT_OSC_ENABLE;
   localparam logic [7:0] GE  = 8'h01 << gtc_pkg::BIT_GATE_ENABLE;

   logic        hclk = 1'b0;          // 10 MHz bus clock
   logic        hresetn = 1'b0;       // async reset, active low
   logic        hsel = 1'b0;          // master side signals
   logic [7:0]  haddr = 8'h00;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic        hreadyout, hresp, hready;
   logic        ext_clk, gate_pin, cmp;   // far-end levels
   logic        sleep_mode = 1'b0;        // system context
   logic        primary_clock_ok = 1'b0;
   logic [1:0]  port_data_in = 2'h0;
   logic [1:0]  port_dir_in = 2'h0;
   logic        osc_run, disp_en, dir_a, dir_b, irq, wake;
   int          mismatches = 0;
   int          samples_checked = 0;
   logic [31:0] rd, rd2;
   logic [7:0]  d;

   assign hready = hreadyout;         // single slave drives hready
   always #50 hclk = ~hclk;

   gtc_timer dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .ext_count_clock_pin(ext_clk), .gate_pin(gate_pin), .second_comparator(cmp),
      .sleep_mode(sleep_mode), .primary_clock_ok(primary_clock_ok),
      .port_data_in(port_data_in), .port_dir_in(port_dir_in), .osc_run(osc_run),
      .display_clock_enable(disp_en), .osc_pin_a_direction(dir_a),
      .osc_pin_b_direction(dir_b), .irq(irq), .wake_request(wake));

   gtc_far_end far (.hclk(hclk), .ext_count_clock_pin(ext_clk), .gate_pin(gate_pin),
      .second_comparator(cmp));

   ////////////////////////////////////////////////////////////////////////////
   // verdict and end of run, the single exit point
   task automatic final_report();
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // one compare, case equality so unknowns never match
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // next edge where hready is high, bounded so a stuck slave cannot hang us
   task automatic wait_ready();
      int n;
      n = 0;
      @(posedge hclk);
      while (hready !== 1'b1) begin
         n++;
         if (n > 100) begin
            mismatches++;
            final_report();
         end
         @(posedge hclk);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // ahb-lite single word write and read, every change right after an edge
   task automatic bus_wr(input logic [7:0] a, input logic [7:0] v);
      hsel <= 1'b1; haddr <= a; hwrite <= 1'b1; htrans <= 2'h2;
      wait_ready();
      htrans <= gtc_pkg::HTRANS_IDLE;
      hwdata <= {24'h0, v};
      wait_ready();
      check("hresp", hresp, gtc_pkg::HRESP_OKAY);
   endtask

   task automatic bus_rd(input logic [7:0] a, output logic [31:0] v);
      hsel <= 1'b1; haddr <= a; hwrite <= 1'b0; htrans <= 2'h2;
      wait_ready();
      htrans <= gtc_pkg::HTRANS_IDLE;
      wait_ready();
      v = hrdata;
   endtask

   // count advance over 2+gap cycles between two low byte samples
   task automatic span(input int gap, output logic [7:0] diff);
      bus_rd(gtc_pkg::OFS_COUNT_LOW, rd);
      repeat (gap) @(posedge hclk);
      bus_rd(gtc_pkg::OFS_COUNT_LOW, rd2);
      diff = rd2[7:0] - rd[7:0];
   endtask

   task automatic wr_count(input logic [15:0] v);
      bus_wr(gtc_pkg::OFS_COUNT_LOW, v[7:0]);
      bus_wr(gtc_pkg::OFS_COUNT_HIGH, v[15:8]);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      // reset values, unmapped place reads zero and ignores writes
      bus_rd(gtc_pkg::OFS_CONTROL, rd);    check("control", rd, 32'h0);
      bus_rd(gtc_pkg::OFS_COMPARATOR, rd); check("gate src", rd, 32'h2);
      bus_wr(8'h20, 8'hA5);
      bus_rd(8'h20, rd);                   check("unmapped", rd, 32'h0);
      // byte writes land in the live counter halves
      wr_count(16'h1234);
      bus_rd(gtc_pkg::OFS_COUNT_LOW, rd);  check("low", rd, 32'h34);
      bus_rd(gtc_pkg::OFS_COUNT_HIGH, rd); check("high", rd, 32'h12);
      // every prescale code: eight increments across 8*ratio cycles
      for (int c = 0; c < 4; c++) begin
         bus_wr(gtc_pkg::OFS_CONTROL, TON | 8'(c << gtc_pkg::BIT_PRESCALE_LO));
         span(8 * (1 << c) - 2, d);        check("presc", d, 32'h8);
      end
      // a count write clears a half-run prescaler: first step 8 cycles later
      repeat (13) @(posedge hclk);
      bus_wr(gtc_pkg::OFS_COUNT_HIGH, 8'h00);
      bus_wr(gtc_pkg::OFS_COUNT_LOW, 8'h00);
      repeat (4) @(posedge hclk);
      bus_rd(gtc_pkg::OFS_COUNT_LOW, rd);  check("psc clr a", rd, 32'h0);
      bus_rd(gtc_pkg::OFS_COUNT_LOW, rd);  check("psc clr b", rd, 32'h0);
      bus_rd(gtc_pkg::OFS_COUNT_LOW, rd);  check("psc clr c", rd, 32'h1);
      // timer off holds the count
      bus_wr(gtc_pkg::OFS_CONTROL, 8'h00);
      span(6, d);                          check("off", d, 32'h0);
      // gate: each source and polarity, other source set opposite
      for (int i = 0; i < 4; i++) begin
         bus_wr(gtc_pkg::OFS_COMPARATOR, 8'(i[1]) << gtc_pkg::BIT_GATE_SOURCE);
         bus_wr(gtc_pkg::OFS_CONTROL, TON | GE | (8'(i[0]) << gtc_pkg::BIT_GATE_INVERT));
         for (int act = 0; act < 2; act++) begin
            d = (act[0] ~^ i[0]) ? 8'h01 : 8'h00;   // selected source level
            far.set_gate(i[1] ? ~d[0] : d[0], i[1] ? d[0] : ~d[0]);
            repeat (4) @(posedge hclk);
            span(6, d);                    check("gate", d, 32'(8 * act));
         end
         bus_wr(gtc_pkg::OFS_CONTROL, TON | (8'(i[0]) << gtc_pkg::BIT_GATE_INVERT));
         span(6, d);                       check("ungated", d, 32'h8);
      end
      // external clock, synchronized then asynchronous: first rise ignored
      for (int s = 0; s < 2; s++) begin
         bus_wr(gtc_pkg::OFS_CONTROL, TON | CS | (s[0] ? SD : 8'h00));
         wr_count(16'h0000);
         far.pulses(5, 4);
         repeat (8) @(posedge hclk);
         bus_rd(gtc_pkg::OFS_COUNT_LOW, rd); check("ext", rd, 32'h4);
      end
      // rollover, flag and the three enables; software clears count first
      bus_wr(gtc_pkg::OFS_CONTROL, 8'h00);
      wr_count(16'h0000);
      bus_wr(gtc_pkg::OFS_IRQ_FLAG, 8'h00);
      bus_wr(gtc_pkg::OFS_IRQ_ENABLE, 8'h01);
      wr_count(gtc_pkg::COUNT_MAX);
      bus_wr(gtc_pkg::OFS_IRQ_CTRL, 8'hC0);
      @(posedge hclk);                     check("irq idle", irq, 1'b0);
      bus_wr(gtc_pkg::OFS_CONTROL, TON);
      repeat (4) @(posedge hclk);
      bus_rd(gtc_pkg::OFS_COUNT_HIGH, rd); check("wrap", rd, 32'h0);
      bus_rd(gtc_pkg::OFS_IRQ_FLAG, rd);   check("flag", rd, 32'h1);
      check("irq", irq, 1'b1);
      bus_wr(gtc_pkg::OFS_IRQ_CTRL, 8'h40);
      repeat (2) @(posedge hclk);          check("irq gie", irq, 1'b0);
      bus_wr(gtc_pkg::OFS_IRQ_CTRL, 8'hC0);
      bus_wr(gtc_pkg::OFS_IRQ_FLAG, 8'h00);
      repeat (2) @(posedge hclk);          check("irq clr", irq, 1'b0);
      // asleep: asynchronous pin counting overflows and asks for wake-up
      bus_wr(gtc_pkg::OFS_CONTROL, CS | SD);
      wr_count(gtc_pkg::COUNT_MAX);
      bus_wr(gtc_pkg::OFS_CONTROL, TON | CS | SD);
      sleep_mode <= 1'b1;
      far.pulses(2, 4);
      repeat (8) @(posedge hclk);          check("wake", wake, 1'b1);
      sleep_mode <= 1'b0;
      // oscillator: needs a compatible primary clock, then forces the pins
      port_data_in <= 2'h3;
      primary_clock_ok <= 1'b1;
      bus_wr(gtc_pkg::OFS_CONTROL, OSC);
      repeat (2) @(posedge hclk);
      check("osc", {osc_run, disp_en, dir_a, dir_b}, 4'hF);
      bus_rd(gtc_pkg::OFS_PIN_VIEW, rd);   check("view on", rd, 32'hC);
      primary_clock_ok <= 1'b0;
      repeat (2) @(posedge hclk);          check("osc off", osc_run, 1'b0);
      bus_rd(gtc_pkg::OFS_PIN_VIEW, rd);   check("view off", rd, 32'h3);
      final_report();
   end
endmodule
